// [core/fhid_pkg.sv]
package fhid_pkg;

	// ==========================================================
	// Timing
	localparam int         CLK_NS       = 25;
	localparam int         MFM_CELL_NS  = 4000;
	localparam int         FM_CELL_NS   = 8000;
	localparam int         PRECOMP_NS   = 125;
	localparam logic [8:0] MFM_CELL_CYC = 9'(MFM_CELL_NS / CLK_NS);
	localparam logic [8:0] FM_CELL_CYC  = 9'(FM_CELL_NS / CLK_NS);
	localparam logic [8:0] PRECOMP_CYC  = 9'(PRECOMP_NS / CLK_NS);

	// ==========================================================
	// Register addresses
	localparam logic [1:0] ADDR_STATE  = 2'h0;
	localparam logic [1:0] ADDR_TRACK  = 2'h1;
	localparam logic [1:0] ADDR_SECTOR = 2'h2;
	localparam logic [1:0] ADDR_HOLD   = 2'h3;

	// ==========================================================
	// Status bit positions
	localparam int ST_BUSY  = 0;
	localparam int ST_DRQ   = 1;
	localparam int ST_INDEX = 1;
	localparam int ST_LOST  = 2;
	localparam int ST_CRC   = 3;
	localparam int ST_RNF   = 4;
	localparam int ST_WPROT = 6;

	// ==========================================================
	// Command word fields
	localparam int         CMD_TYPE_BIT  = 7;
	localparam logic [3:0] CMD_FORCE     = 4'hD;
	localparam logic [2:0] CMD_RD_SEC    = 3'h4;
	localparam logic [2:0] CMD_WR_SEC    = 3'h5;
	localparam logic [3:0] CMD_RD_ADDR   = 4'hC;
	localparam logic [3:0] CMD_RD_TRK    = 4'hE;
	localparam logic [3:0] CMD_WR_TRK    = 4'hF;
	localparam int         PRECOMP_BIT   = 1;
	localparam int         FI_INDEX_BIT  = 2;
	localparam int         FI_IMMED_BIT  = 3;

	// ==========================================================
	// CRC and sector sizes
	localparam logic [15:0] CRC_POLY   = 16'h1021;
	localparam logic [15:0] CRC_PRESET = 16'hFFFF;
	localparam logic [10:0] SECLEN_0   = 11'h080;
	localparam logic [10:0] SECLEN_1   = 11'h100;
	localparam logic [10:0] SECLEN_2   = 11'h200;
	localparam logic [10:0] SECLEN_3   = 11'h400;

	localparam int BYTE_W     = 8;
	localparam int FIFO_DEPTH = 8;

	typedef enum logic [1:0] {
		WR_IDLE = 2'b00,
		WR_WAIT = 2'b01,
		WR_RUN  = 2'b10
	} fhid_wr_t;

endpackage

// [core/fhid_top.sv]
// Function
// RQ1: Address and read/write pick one register
// RQ2: Drive bus only on selected reads
// RQ3: Command word writable, reads return status
// RQ4: Status read-only, meaning follows command type
// RQ5: Track count follows head steps
// RQ6: Compare ID track and sector fields
// RQ7: Host avoids register writes while busy
// RQ8: Holding register gives seek target track
// RQ9: CRC-16 preset ones, poly 1021
// RQ10: Density input low selects MFM
// RQ11: Read byte loads holding, raises request
// RQ12: Request mirrored in status bit one
// RQ13: Host holding read clears request
// RQ14: Overwritten unread byte sets lost data
// RQ15: Write copy raises request, host write drops
// RQ16: Late host byte writes zero, lost
// RQ17: Interrupt on completion, cleared by access
// RQ18: Write gate waits for first byte
// RQ19: Write protect aborts write with interrupt
// RQ20: MFM precompensation shifts pulses 125 ns
// RQ21: ID size code gives sector length
// RQ22: Any 8-bit track and sector numbers
// RQ23: Busy during command, cleared at end
// RQ24: Command bit one low enables precompensation
// RQ25: Reset initialises status and registers
// RQ26: CRC shifts most significant bit first
`timescale 1ns/1ps

// ==========================================================
// Byte FIFO between the read byte source and the holding register
module fhid_fifo #(
	parameter int W = 8,
	parameter int D = 8
) (
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic         flush,
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic      [W-1:0] out_data
);
	localparam int AW = $clog2(D);

	logic [W-1:0] mem [D];
	logic [AW:0]  wr_ptr_ff;
	logic [AW:0]  rd_ptr_ff;

	assign out_valid = wr_ptr_ff != rd_ptr_ff;
	assign in_ready  = !((wr_ptr_ff[AW] != rd_ptr_ff[AW]) &&
		(wr_ptr_ff[AW-1:0] == rd_ptr_ff[AW-1:0]));
	assign out_data  = mem[rd_ptr_ff[AW-1:0]];

	always_ff @(posedge clk) begin
		if (in_valid && in_ready) begin
			mem[wr_ptr_ff[AW-1:0]] <= in_data;
		end
	end

	always_ff @(posedge clk) begin
		if (rst || flush) begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
		end else begin
			if (in_valid && in_ready) begin
				wr_ptr_ff <= wr_ptr_ff + 1'b1;
			end
			if (out_valid && out_ready) begin
				rd_ptr_ff <= rd_ptr_ff + 1'b1;
			end
		end
	end
endmodule

// ==========================================================
// Host port, status, transfer handshake, CRC and write encoder
module fhid_top
	import fhid_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        chip_select_n,
	input  wire logic        rw,
	input  wire logic [1:0]  register_select,
	input  wire logic [7:0]  host_bus_in,
	output logic      [7:0]  host_bus_out,
	output logic             host_bus_oe,
	input  wire logic        density_select_n,
	input  wire logic        write_protect_n,
	input  wire logic        index_n,
	input  wire logic        step_in,
	input  wire logic        step_out,
	input  wire logic        op_done,
	input  wire logic        op_error,
	input  wire logic        crc_preset,
	input  wire logic        id_valid,
	input  wire logic [7:0]  id_track,
	input  wire logic [7:0]  id_sector,
	input  wire logic [7:0]  id_size,
	input  wire logic        rd_byte_valid,
	input  wire logic [7:0]  rd_byte,
	output logic             rd_byte_ready,
	output logic             op_start,
	output logic             op_abort,
	output logic      [7:0]  op_code,
	output logic             busy,
	output logic      [7:0]  seek_target,
	output logic             id_match,
	output logic      [10:0] sector_len,
	output logic      [15:0] crc_value,
	output logic             mfm_mode,
	output logic             transfer_request,
	output logic             completion_irq,
	output logic             write_gate_out,
	output logic             write_pulse_out
);

	// ==========================================================
	// Pin synchronisers
	logic [14:0] pin_s1_ff;
	logic [14:0] pin_s2_ff;
	logic        cs_n_s;
	logic        rw_s;
	logic [1:0]  addr_s;
	logic [7:0]  bus_s;
	logic        dens_n_s;
	logic        wp_n_s;
	logic        idx_n_s;

	always_ff @(posedge clk) begin
		if (rst) begin
			pin_s1_ff <= 15'h7FFF;
			pin_s2_ff <= 15'h7FFF;
		end else begin
			pin_s1_ff <= {chip_select_n, rw, register_select, host_bus_in,
				density_select_n, write_protect_n, index_n};
			pin_s2_ff <= pin_s1_ff;
		end
	end

	assign {cs_n_s, rw_s, addr_s, bus_s, dens_n_s, wp_n_s, idx_n_s} = pin_s2_ff;

	// ==========================================================
	// Access framing
	logic       cs_prev_ff;
	logic       idx_prev_ff;
	logic       acc_rw_ff;
	logic [1:0] acc_addr_ff;
	logic       acc_start;
	logic       acc_end;
	logic       wr_strobe;
	logic       rd_done;
	logic       idx_fall;

	always_ff @(posedge clk) begin
		if (rst) begin
			cs_prev_ff  <= 1'b1;
			idx_prev_ff <= 1'b1;
			acc_rw_ff   <= 1'b1;
			acc_addr_ff <= ADDR_STATE;
		end else begin
			cs_prev_ff  <= cs_n_s;
			idx_prev_ff <= idx_n_s;
			if (acc_start) begin
				acc_rw_ff   <= rw_s;
				acc_addr_ff <= addr_s;
			end
		end
	end

	// Writes are taken as the select falls; read side effects wait until it
	// rises so a byte is never consumed while the host still samples it
	assign acc_start = cs_prev_ff && !cs_n_s;
	assign acc_end   = !cs_prev_ff && cs_n_s;
	assign wr_strobe = acc_start && !rw_s; // RQ1
	assign rd_done   = acc_end && acc_rw_ff; // RQ1
	assign idx_fall  = idx_prev_ff && !idx_n_s;

	// ==========================================================
	// Command decode
	logic     cmd_wr;
	logic     force_cmd;
	logic     cmd_is_wr;
	logic     cmd_is_rd;
	logic     wp_abort;
	logic     cmd_accept;
	logic     end_evt;
	logic     mfm;
	logic     rd_pop;
	logic     wr_load;
	logic     byte_end;
	logic     wr_copy;
	logic     rd_op;
	logic     fifo_out_valid;
	logic     fifo_out_ready;
	logic     fifo_in_ready;
	logic [7:0] fifo_out;
	logic [7:0] wr_byte;

	assign cmd_wr     = wr_strobe && addr_s == ADDR_STATE; // RQ1
	assign force_cmd  = cmd_wr && bus_s[7:4] == CMD_FORCE;
	assign cmd_is_wr  = bus_s[7:5] == CMD_WR_SEC || bus_s[7:4] == CMD_WR_TRK;
	assign cmd_is_rd  = bus_s[7:5] == CMD_RD_SEC || bus_s[7:4] == CMD_RD_ADDR ||
		bus_s[7:4] == CMD_RD_TRK;
	assign wp_abort   = cmd_wr && cmd_is_wr && !wp_n_s; // RQ19
	assign cmd_accept = cmd_wr && !force_cmd && !wp_abort;
	assign mfm        = !dens_n_s; // RQ10

	logic [7:0] op_word_ff;
	logic       is_rd_ff;
	logic       is_wr_ff;
	logic       type1_ff;
	logic       busy_ff;
	logic       op_start_ff;
	logic       op_abort_ff;

	always_ff @(posedge clk) begin
		if (rst) begin
			op_word_ff  <= 8'h00;
			is_rd_ff    <= 1'b0;
			is_wr_ff    <= 1'b0;
			type1_ff    <= 1'b1;
			op_start_ff <= 1'b0;
			op_abort_ff <= 1'b0;
		end else begin
			op_start_ff <= cmd_accept;
			op_abort_ff <= force_cmd;
			if (cmd_wr) begin
				op_word_ff <= bus_s; // RQ3
				is_rd_ff   <= cmd_is_rd && !force_cmd;
				is_wr_ff   <= cmd_is_wr && !force_cmd;
				type1_ff   <= !bus_s[CMD_TYPE_BIT]; // RQ4
			end
		end
	end

	assign end_evt = busy_ff && op_done;
	assign rd_op   = busy_ff && is_rd_ff;

	always_ff @(posedge clk) begin
		if (rst) begin
			busy_ff <= 1'b0; // RQ25
		end else if (cmd_accept) begin
			busy_ff <= 1'b1; // RQ23
		end else if (end_evt || force_cmd) begin
			busy_ff <= 1'b0; // RQ23
		end
	end

	// ==========================================================
	// Track, sector, holding and ID compare
	logic [7:0]  track_ff;
	logic [7:0]  sector_ff;
	logic [7:0]  hold_ff;
	logic        id_match_ff;
	logic [10:0] sector_len_ff;

	always_ff @(posedge clk) begin
		if (rst) begin
			track_ff  <= 8'h00;
			sector_ff <= 8'h00;
		end else begin
			if (wr_strobe && addr_s == ADDR_TRACK) begin
				track_ff <= bus_s;
			end else if (step_in && !step_out) begin
				track_ff <= track_ff + 8'h01; // RQ5 RQ22
			end else if (step_out && !step_in) begin
				track_ff <= track_ff - 8'h01; // RQ5
			end
			if (wr_strobe && addr_s == ADDR_SECTOR) begin
				sector_ff <= bus_s;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			hold_ff <= 8'h00;
		end else if (wr_strobe && addr_s == ADDR_HOLD) begin
			hold_ff <= bus_s;
		end else if (rd_pop) begin
			hold_ff <= fifo_out; // RQ11
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			id_match_ff   <= 1'b0;
			sector_len_ff <= SECLEN_0;
		end else if (id_valid) begin
			id_match_ff <= id_track == track_ff && id_sector == sector_ff; // RQ6 RQ22
			case (id_size[1:0]) // RQ21
				2'h0: sector_len_ff <= SECLEN_0;
				2'h1: sector_len_ff <= SECLEN_1;
				2'h2: sector_len_ff <= SECLEN_2;
				default: sector_len_ff <= SECLEN_3;
			endcase
		end
	end

	// ==========================================================
	// Read path
	// The drain stalls while the host is reading the holding register
	assign fifo_out_ready = rd_op && !(!cs_n_s && rw_s && addr_s == ADDR_HOLD);
	assign rd_pop         = fifo_out_valid && fifo_out_ready;
	assign rd_byte_ready  = fifo_in_ready && rd_op;

	fhid_fifo #(
		.W (BYTE_W),
		.D (FIFO_DEPTH)
	) u_rd_fifo (
		.clk       (clk),
		.rst       (rst),
		.flush     (cmd_accept),
		.in_valid  (rd_byte_valid && rd_op),
		.in_ready  (fifo_in_ready),
		.in_data   (rd_byte),
		.out_valid (fifo_out_valid),
		.out_ready (fifo_out_ready),
		.out_data  (fifo_out)
	);

	// ==========================================================
	// Transfer request and interrupt; a set always beats a clear
	logic drq_ff;
	logic irq_ff;
	logic fi_idx_ff;
	logic drq_set;
	logic drq_clr;
	logic irq_set;
	logic irq_clr;
	logic wr_begin;

	assign wr_begin = cmd_accept && cmd_is_wr;
	assign drq_set  = rd_pop || wr_load || wr_begin; // RQ11 RQ15
	assign drq_clr  = (rd_done && acc_addr_ff == ADDR_HOLD && is_rd_ff) || // RQ13
		(wr_strobe && addr_s == ADDR_HOLD) || cmd_wr || end_evt; // RQ15
	assign irq_set  = end_evt || wp_abort || (force_cmd && bus_s[FI_IMMED_BIT]) ||
		(fi_idx_ff && idx_fall); // RQ17
	assign irq_clr  = (rd_done && acc_addr_ff == ADDR_STATE) || cmd_wr; // RQ17

	always_ff @(posedge clk) begin
		if (rst) begin
			drq_ff <= 1'b0;
		end else if (drq_set) begin
			drq_ff <= 1'b1;
		end else if (drq_clr) begin
			drq_ff <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			irq_ff    <= 1'b0;
			fi_idx_ff <= 1'b0;
		end else begin
			if (irq_set) begin
				irq_ff <= 1'b1; // RQ17 RQ23
			end else if (irq_clr) begin
				irq_ff <= 1'b0;
			end
			if (force_cmd) begin
				fi_idx_ff <= bus_s[FI_INDEX_BIT];
			end else if (cmd_accept) begin
				fi_idx_ff <= 1'b0;
			end
		end
	end

	// ==========================================================
	// Status flags
	logic lost_ff;
	logic crc_err_ff;
	logic rnf_ff;
	logic wprot_ff;
	logic [15:0] crc_ff;

	always_ff @(posedge clk) begin
		if (rst || cmd_accept) begin
			lost_ff    <= 1'b0; // RQ25
			crc_err_ff <= 1'b0;
			rnf_ff     <= 1'b0;
			wprot_ff   <= 1'b0;
		end else begin
			if ((rd_pop || byte_end) && drq_ff) begin
				lost_ff <= 1'b1; // RQ14 RQ16
			end
			if (end_evt && is_rd_ff && crc_ff != 16'h0000) begin
				crc_err_ff <= 1'b1;
			end
			if (end_evt && op_error) begin
				rnf_ff <= 1'b1;
			end
			if (wp_abort) begin
				wprot_ff <= 1'b1; // RQ19
			end
		end
	end

	logic [7:0] status_word;
	logic [7:0] rd_mux;
	logic [7:0] host_out_ff;

	always_comb begin
		status_word           = 8'h00;
		status_word[ST_BUSY]  = busy_ff; // RQ23
		status_word[ST_CRC]   = crc_err_ff;
		status_word[ST_RNF]   = rnf_ff;
		status_word[ST_WPROT] = wprot_ff;
		if (type1_ff) begin
			status_word[ST_INDEX] = !idx_n_s; // RQ4
		end else begin
			status_word[ST_DRQ]  = drq_ff; // RQ12
			status_word[ST_LOST] = lost_ff;
		end
	end

	always_comb begin
		case (addr_s) // RQ1
			ADDR_STATE:  rd_mux = status_word; // RQ3
			ADDR_TRACK:  rd_mux = track_ff;
			ADDR_SECTOR: rd_mux = sector_ff;
			default:     rd_mux = hold_ff;
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			host_out_ff <= 8'h00;
		end else if (!cs_n_s && rw_s) begin
			host_out_ff <= rd_mux;
		end
	end

	assign host_bus_oe = !cs_n_s && rw_s; // RQ2

	// ==========================================================
	// CRC over every byte from the address mark onward
	function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
		logic [15:0] r;
		r = c;
		for (int i = 7; i >= 0; i--) begin
			r = (r[15] ^ d[i]) ? ((r << 1) ^ CRC_POLY) : (r << 1); // RQ9 RQ26
		end
		return r;
	endfunction

	always_ff @(posedge clk) begin
		if (rst || crc_preset || wr_begin) begin
			crc_ff <= CRC_PRESET; // RQ9
		end else if (rd_pop) begin
			crc_ff <= crc_byte(crc_ff, fifo_out);
		end else if (wr_load) begin
			crc_ff <= crc_byte(crc_ff, wr_byte);
		end
	end

	// ==========================================================
	// Write serialiser and MFM/FM encoder with precompensation
	fhid_wr_t   wr_st_ff;
	logic       wg_ff;
	logic       pc_on_ff;
	logic [7:0] wsh_ff;
	logic [2:0] bit_idx_ff;
	logic [8:0] cell_cnt_ff;
	logic       prev_ff;
	logic       older_ff;
	logic       pulse_ff;
	logic [8:0] cell_len;
	logic       cell_end;
	logic       cur_bit;
	logic       next_bit;
	logic       pc;
	logic [8:0] clk_pos;
	logic [8:0] dat_pos;
	logic       want_clk;
	logic       nxt_pulse;

	assign cell_len = mfm ? MFM_CELL_CYC : FM_CELL_CYC;
	assign cell_end = cell_cnt_ff == cell_len - 9'h001;
	assign byte_end = wr_st_ff == WR_RUN && cell_end && bit_idx_ff == 3'h0;
	assign wr_copy  = wr_st_ff == WR_WAIT && !drq_ff; // RQ18
	assign wr_load  = wr_copy || byte_end;
	assign wr_byte  = (byte_end && drq_ff) ? 8'h00 : hold_ff; // RQ16
	assign cur_bit  = wsh_ff[7];
	assign next_bit = (bit_idx_ff == 3'h0) ? (!drq_ff && hold_ff[7]) : wsh_ff[6];
	assign pc       = mfm && pc_on_ff; // RQ20
	assign want_clk = !mfm || (!prev_ff && !cur_bit);

	always_comb begin
		clk_pos = PRECOMP_CYC;
		dat_pos = {1'b0, cell_len[8:1]};
		if (pc && next_bit && !older_ff) begin
			clk_pos = clk_pos - PRECOMP_CYC; // RQ20
		end else if (pc && older_ff && !next_bit) begin
			clk_pos = clk_pos + PRECOMP_CYC;
		end
		if (pc && prev_ff && !next_bit) begin
			dat_pos = dat_pos - PRECOMP_CYC; // RQ20
		end else if (pc && !prev_ff && next_bit) begin
			dat_pos = dat_pos + PRECOMP_CYC;
		end
		nxt_pulse = wg_ff && wr_st_ff == WR_RUN &&
			((want_clk && cell_cnt_ff == clk_pos) || (cur_bit && cell_cnt_ff == dat_pos));
	end

	always_ff @(posedge clk) begin
		if (rst || force_cmd || end_evt) begin
			wr_st_ff    <= WR_IDLE;
			wg_ff       <= 1'b0;
			cell_cnt_ff <= 9'h000;
			bit_idx_ff  <= 3'h7;
			prev_ff     <= 1'b0;
			older_ff    <= 1'b0;
			wsh_ff      <= 8'h00;
		end else begin
			case (wr_st_ff)
				WR_IDLE: begin
					if (wr_begin) begin
						wr_st_ff <= WR_WAIT;
						pc_on_ff <= !bus_s[PRECOMP_BIT]; // RQ24
					end
				end
				WR_WAIT: begin
					if (wr_copy) begin
						wr_st_ff    <= WR_RUN;
						wg_ff       <= 1'b1; // RQ18
						wsh_ff      <= wr_byte;
						cell_cnt_ff <= 9'h000;
						bit_idx_ff  <= 3'h7;
					end
				end
				WR_RUN: begin
					cell_cnt_ff <= cell_end ? 9'h000 : cell_cnt_ff + 9'h001;
					if (cell_end) begin
						older_ff   <= prev_ff;
						prev_ff    <= cur_bit;
						bit_idx_ff <= bit_idx_ff - 3'h1;
						wsh_ff     <= byte_end ? wr_byte : {wsh_ff[6:0], 1'b0}; // RQ15
					end
				end
				default: wr_st_ff <= WR_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			pulse_ff <= 1'b0;
		end else begin
			pulse_ff <= nxt_pulse;
		end
	end

	// ==========================================================
	// Outputs
	assign host_bus_out     = host_out_ff;
	assign op_start         = op_start_ff;
	assign op_abort         = op_abort_ff;
	assign op_code          = op_word_ff;
	assign busy             = busy_ff;
	assign seek_target      = hold_ff; // RQ8
	assign id_match         = id_match_ff;
	assign sector_len       = sector_len_ff;
	assign crc_value        = crc_ff;
	assign mfm_mode         = mfm;
	assign transfer_request = drq_ff;
	assign completion_irq   = irq_ff;
	assign write_gate_out   = wg_ff;
	assign write_pulse_out  = pulse_ff;

	// ==========================================================
	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	chk_bus_drive: assert property (host_bus_oe |-> !$past(chip_select_n, 2) && $past(rw, 2)) // RQ2
		else $error("bus driven without a selected read");
	chk_status_read: assert property (!cs_n_s && rw_s && addr_s == ADDR_STATE
		|=> host_bus_out == $past(status_word)) // RQ3
		else $error("command address did not return status");
	chk_track_step: assert property (step_in && !step_out && !(wr_strobe && addr_s == ADDR_TRACK)
		|=> track_ff == $past(track_ff) + 8'h01) // RQ5
		else $error("track did not follow step in");
	chk_read_request: assert property (rd_pop |=> transfer_request && hold_ff == $past(fifo_out)) // RQ11
		else $error("read byte not presented with request");
	chk_lost_read: assert property (rd_pop && drq_ff |=> lost_ff) // RQ14
		else $error("overwritten byte not flagged lost");
	chk_gate_first: assert property ($rose(write_gate_out) |-> $past(wr_st_ff) == WR_WAIT
		&& !$past(drq_ff)) // RQ18
		else $error("write gate before first byte");
	chk_wp_abort: assert property (wp_abort |=> wprot_ff && completion_irq && !busy_ff) // RQ19
		else $error("protected write not aborted");
	chk_busy_done: assert property (end_evt && !cmd_wr |=> !busy_ff ##0 completion_irq) // RQ23
		else $error("completion did not drop busy and interrupt");
	chk_irq_clear: assert property (irq_clr && !irq_set |=> !completion_irq) // RQ17
		else $error("interrupt not cleared by access");
	chk_crc_preset: assert property (crc_preset |=> crc_value == CRC_PRESET) // RQ9
		else $error("crc not preset to ones");

	cov_read_byte: cover property (rd_pop ##[1:200] rd_done && acc_addr_ff == ADDR_HOLD);
	cov_write_start: cover property (wr_begin ##[1:300] $rose(write_gate_out));
	cov_lost_write: cover property (byte_end && drq_ff);
	cov_wp_abort: cover property (wp_abort);
endmodule

// [test/fhid_host_model.sv]
`timescale 1ns/1ps

// ========
// Processor side of the parallel register port
module fhid_host_model (
	input  wire logic       clk,
	output logic            chip_select_n,
	output logic            rw,
	output logic [1:0]      register_select,
	output logic [7:0]      host_bus_in,
	input  wire logic [7:0] host_bus_out,
	input  wire logic       host_bus_oe
);
	initial begin
		chip_select_n = 1'h1;
		rw = 1'h1;
		register_select = 2'h0;
		host_bus_in = 8'h00;
	end

	// Callers only write track, sector or command while idle, force excepted
	task automatic acc(input logic r, input logic [1:0] a, input logic [7:0] d,
			output logic [7:0] q);
		rw = r;
		register_select = a;
		// On a read the host lets go, so the wire shows a changing level
		host_bus_in = r ? ~host_bus_in : d;
		repeat (3) @(negedge clk);
		chip_select_n = 1'h0;
		repeat (6) @(negedge clk);
		q = host_bus_oe ? host_bus_out : ~host_bus_out;
		chip_select_n = 1'h1;
		@(negedge clk);
		host_bus_in = ~host_bus_in;
		repeat (5) @(negedge clk);
	endtask
endmodule

// [test/tb_top.sv]
`timescale 1ns/1ps

module tb_top import fhid_pkg::*;;
	logic        clk, rst, chip_select_n, rw, density_select_n, write_protect_n;
	logic        step_in, step_out, op_done, id_valid, rd_byte_valid, rd_byte_ready, crc_preset;
	logic        host_bus_oe, op_start, op_abort, busy, id_match, mfm_mode;
	logic        transfer_request, completion_irq, write_gate_out, write_pulse_out;
	logic [1:0]  register_select;
	logic [7:0]  host_bus_in, host_bus_out, id_track, id_sector, id_size, rd_byte;
	logic [7:0]  op_code, seek_target, q;
	logic [10:0] sector_len;
	logic [15:0] crc_value;
	int          fails, checks_done;

	fhid_host_model u_fhid_host_model (.clk, .chip_select_n, .rw, .register_select,
		.host_bus_in, .host_bus_out, .host_bus_oe);
	// Index and error flag belong to the sequencer, held quiet here
	fhid_top u_fhid_top (.clk, .rst, .chip_select_n, .rw, .register_select,
		.host_bus_in, .host_bus_out, .host_bus_oe, .density_select_n,
		.write_protect_n, .index_n(1'h1), .step_in, .step_out, .op_done,
		.op_error(1'h0), .crc_preset, .id_valid, .id_track, .id_sector,
		.id_size, .rd_byte_valid, .rd_byte, .rd_byte_ready, .op_start, .op_abort,
		.op_code, .busy, .seek_target, .id_match, .sector_len, .crc_value,
		.mfm_mode, .transfer_request, .completion_irq, .write_gate_out,
		.write_pulse_out);

	always #12.5 clk = ~clk;

	// ========
	// Helpers
	task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
		checks_done++;
		if (s !== e) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic wr(input logic [1:0] a, input logic [7:0] d);
		u_fhid_host_model.acc(1'h0, a, d, q);
	endtask
	task automatic rd(input logic [1:0] a);
		u_fhid_host_model.acc(1'h1, a, 8'h00, q);
	endtask
	task automatic pulse(ref logic s);
		@(negedge clk) s = 1'h1;
		@(negedge clk) s = 1'h0;
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// ========
	// Scenarios
	task automatic t_regs();
		chk("busy", busy, 1'h0);
		chk("seclen", sector_len, 11'h080);
		wr(ADDR_SECTOR, 8'hFF);
		rd(ADDR_SECTOR);
		chk("sector", q, 8'hFF);
		wr(ADDR_TRACK, 8'h10);
		pulse(step_in);
		rd(ADDR_TRACK);
		chk("track", q, 8'h11);
		pulse(step_out);
		pulse(step_out);
		rd(ADDR_TRACK);
		chk("track", q, 8'h0F);
	endtask

	task automatic t_read();
		wr(ADDR_STATE, 8'h80);
		chk("busy", busy, 1'h1);
		rd(ADDR_STATE);
		chk("status", q, 8'h01);
		pulse(crc_preset);
		chk("crc", crc_value, CRC_PRESET);
		@(negedge clk) {rd_byte_valid, rd_byte} = 9'h15A;
		@(negedge clk) rd_byte = 8'hA5;
		@(negedge clk) rd_byte_valid = 1'h0;
		repeat (4) @(negedge clk);
		chk("request", transfer_request, 1'h1);
		// Bytes 5A then A5 through the ones-preset register, MSB first
		chk("crc", crc_value, 16'h1934);
		rd(ADDR_STATE);
		chk("status", q, 8'h07);
		rd(ADDR_HOLD);
		chk("hold", q, 8'hA5);
		chk("request", transfer_request, 1'h0);
		pulse(op_done);
		chk("busy", busy, 1'h0);
		chk("irq", completion_irq, 1'h1);
		rd(ADDR_STATE);
		chk("irq", completion_irq, 1'h0);
	endtask

	task automatic t_id();
		wr(ADDR_TRACK, 8'h21);
		wr(ADDR_SECTOR, 8'h07);
		wr(ADDR_HOLD, 8'h42);
		chk("seek", seek_target, 8'h42);
		{id_track, id_sector} = 16'h2107;
		for (int i = 0; i < 4; i++) begin
			id_size = 8'(i);
			pulse(id_valid);
			chk("seclen", sector_len, 11'h080 << i);
			chk("match", id_match, 1'h1);
		end
		id_sector = 8'h08;
		pulse(id_valid);
		chk("match", id_match, 1'h0);
	endtask

	task automatic t_write();
		int n = 0;
		density_select_n = 1'h1;
		repeat (4) @(negedge clk);
		chk("mfm", mfm_mode, 1'h0);
		density_select_n = 1'h0;
		repeat (4) @(negedge clk);
		chk("mfm", mfm_mode, 1'h1);
		wr(ADDR_STATE, 8'hA0);
		chk("request", transfer_request, 1'h1);
		chk("gate", write_gate_out, 1'h0);
		wr(ADDR_HOLD, 8'h3C);
		chk("gate", write_gate_out, 1'h1);
		chk("request", transfer_request, 1'h1);
		// No second byte: after the first the stream is zeros, one clock pulse per cell
		repeat (1300) @(negedge clk);
		repeat (8 * MFM_CELL_CYC) begin
			@(negedge clk);
			n += write_pulse_out;
		end
		chk("pulses", 16'(n), 16'h0008);
		rd(ADDR_STATE);
		chk("lost", q[ST_LOST], 1'h1);
		pulse(op_done);
		@(negedge clk);
		chk("gate", write_gate_out, 1'h0);
		rd(ADDR_STATE);
		chk("irq", completion_irq, 1'h0);
		write_protect_n = 1'h0;
		repeat (4) @(negedge clk);
		wr(ADDR_STATE, 8'hA0);
		chk("busy", busy, 1'h0);
		chk("irq", completion_irq, 1'h1);
		rd(ADDR_STATE);
		// Lost data from the underrun stays until a command is accepted
		chk("status", q, 8'h44);
		wr(ADDR_STATE, 8'hD8);
		chk("irq", completion_irq, 1'h1);
		chk("opcode", op_code, 8'hD8);
	endtask

	initial begin
		clk = 1'h0;
		rst = 1'h1;
		{density_select_n, write_protect_n, step_in, step_out, op_done, crc_preset} = 6'h30;
		{id_valid, rd_byte_valid, id_track, id_sector, id_size, rd_byte} = 34'h0;
		fails = 0;
		checks_done = 0;
		repeat (8) @(negedge clk);
		rst = 1'h0;
		repeat (3) @(negedge clk);
		t_regs();
		t_read();
		t_id();
		t_write();
		give_verdict();
	end

	initial begin
		#(12000 * 25);
		fails++;
		give_verdict();
	end
endmodule
